/* rtl/rsd_decoder_map.vh */
// How it works
// - syndrome stage forms 2t syndromes per codeword
// - clean codeword yields all-zero syndromes
// - erased symbols build the erasure polynomial
// - key equation yields locator and evaluator
// - chien search and forney give positions, values
// - fifo delays symbols until their correction
// - corrector xors error value into symbol
// - valid flag only during message symbols
// - corrected flag marks altered message symbols
// - uncorrectable flag covers the whole codeword
// - message symbols first, parity symbols last
// - corrects whenever 2e+s <= n-k = 2t
`ifndef RSD_DECODER_MAP_VH
`define RSD_DECODER_MAP_VH

`define RSD_SYM_W      8
`define RSD_PRIM_POLY  8'h1d
`define RSD_N          6'h20
`define RSD_K          6'h1c
`define RSD_LAST       6'h1f
`define RSD_NPAR       4
`define RSD_ERASE_MAX  3'h4
`define RSD_ERASE_SAT  3'h5
`define RSD_KEY_LAST   3'h3
`define RSD_FIFO_DEPTH 32
`define RSD_FIFO_AW    5

`endif

/* rtl/rsd_fifo.v */
`timescale 1ns/1ps
`default_nettype none
module rsd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clock,    // system clock
  input  wire             rstn,     // synchronised reset, active low
  input  wire             clear,    // drop contents, keep a same-cycle push
  input  wire [WIDTH-1:0] inData,   // write data
  input  wire             inValid,  // write request
  output wire             inReady,  // room for one more word
  output wire [WIDTH-1:0] outData,  // head word, show-ahead
  output wire             outValid, // head word present
  input  wire             outReady  // consumer takes head word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr;
  reg [AW-1:0]    rdPtr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign inReady  = (count != DEPTH[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady & ~clear;

  always @(posedge clock) begin
    if (push) begin
      mem[clear ? {AW{1'b0}} : wrPtr] <= inData;
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (clear) begin
      // a sync in mid-codeword restarts the delay line with the new symbol
      wrPtr <= push ? {{(AW-1){1'b0}}, 1'b1} : {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= push ? {{AW{1'b0}}, 1'b1} : {(AW+1){1'b0}};
    end else begin
      if (push) wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
      if (pop) rdPtr <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop) count <= count + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push) count <= count - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // rsd_fifo
`default_nettype wire

/* rtl/rsd_syndrome.v */
`timescale 1ns/1ps
`default_nettype none
`include "rsd_decoder_map.vh"
module rsd_syndrome (
  input  wire        clock,    // system clock
  input  wire        rstn,     // synchronised reset, active low
  input  wire        take,     // symbol accepted this cycle
  input  wire        first,    // accepted symbol starts a codeword
  input  wire [7:0]  sym,      // received symbol
  input  wire        erase,    // symbol is flagged as erased
  output reg  [31:0] synd,     // syndromes s0..s3, s0 in low byte
  output reg  [39:0] gamma,    // erasure locator, degree 0 in low byte
  output reg  [2:0]  eraseCnt  // erasures seen, saturates at five
);
  reg [31:0] next_synd;
  reg [39:0] next_gamma;
  reg [2:0]  next_eraseCnt;
  reg [7:0]  next_pos;
  reg [7:0]  pos;
  reg [31:0] sBase;
  reg [39:0] gBase;
  reg [2:0]  cBase;
  reg [7:0]  pBase;
  integer    i;

  function [7:0] gfMul;
    input [7:0] a;
    input [7:0] b;
    integer     j;
    reg [7:0]   r;
    begin
      r = 8'h00;
      for (j = 7; j >= 0; j = j - 1) begin
        r = {r[6:0], 1'b0} ^ (r[7] ? `RSD_PRIM_POLY : 8'h00);
        if (b[j]) r = r ^ a;
      end
      gfMul = r;
    end
  endfunction

  function [7:0] gfPowA;
    input integer e;
    integer       j;
    reg [7:0]     r;
    begin
      r = 8'h01;
      for (j = 0; j < 255; j = j + 1) begin
        if (j < e) r = gfMul(r, 8'h02);
      end
      gfPowA = r;
    end
  endfunction

  always @* begin
    next_synd     = synd;
    next_gamma    = gamma;
    next_eraseCnt = eraseCnt;
    next_pos      = pos;
    sBase         = first ? 32'h0000_0000 : synd;
    gBase         = first ? 40'h00_0000_0001 : gamma;
    cBase         = first ? 3'h0 : eraseCnt;
    pBase         = first ? gfPowA(`RSD_N - 1) : pos;
    if (take) begin
      // horner per root a^i, codeword symbols as coefficients, highest first
      for (i = 0; i < `RSD_NPAR; i = i + 1) begin
        next_synd[i*8 +: 8] = gfMul(sBase[i*8 +: 8], gfPowA(i)) ^ sym;
      end
      next_gamma    = gBase;
      next_eraseCnt = cBase;
      if (erase && cBase != `RSD_ERASE_SAT) begin
        // multiply in (1 + X x) for this position
        for (i = 1; i <= `RSD_NPAR; i = i + 1) begin
          next_gamma[i*8 +: 8] = gBase[i*8 +: 8] ^ gfMul(pBase, gBase[(i-1)*8 +: 8]);
        end
        next_eraseCnt = cBase + 3'h1;
      end
      next_pos = gfMul(pBase, gfPowA(254));
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      synd     <= 32'h0000_0000;
      gamma    <= 40'h00_0000_0001;
      eraseCnt <= 3'h0;
      pos      <= 8'h01;
    end else begin
      synd     <= next_synd;
      gamma    <= next_gamma;
      eraseCnt <= next_eraseCnt;
      pos      <= next_pos;
    end
  end
endmodule // rsd_syndrome
`default_nettype wire

/* rtl/rsd_decoder.v */
`timescale 1ns/1ps
`default_nettype none
`include "rsd_decoder_map.vh"
module rsd_decoder (
  input  wire       clock,                    // system clock, 200 MHz
  input  wire       rst_n,                    // asynchronous reset, active low
  input  wire [7:0] rx_symbol_in,             // received symbol
  input  wire       syncFlag,                 // first symbol of a codeword
  input  wire       eraseFlag,                // symbol judged unreliable
  input  wire       clock_gate_enable,        // symbol qualifier
  output reg        symbolReady,              // decoder takes symbols
  output reg  [7:0] fixed_symbol_out,         // corrected symbol
  output reg        message_valid_flag,       // message symbol on output
  output reg        correctedFlag,            // output message symbol was altered
  output reg        uncorrectable_block_flag  // codeword beyond repair
);
  localparam ST_COLLECT = 3'h0;
  localparam ST_INIT    = 3'h1;
  localparam ST_KEY     = 3'h2;
  localparam ST_OMEGA   = 3'h3;
  localparam ST_CHECK   = 3'h4;
  localparam ST_FIX     = 3'h5;

  reg  [1:0]  rstPipe;
  wire        rstn;
  reg  [2:0]  state;
  reg  [5:0]  cnt;
  reg  [2:0]  kr;
  reg  [39:0] lam;
  reg  [39:0] bpol;
  reg  [3:0]  lenL;
  reg  [39:0] lamTerm;
  reg  [31:0] omTerm;
  reg  [3:0]  rootCnt;
  reg  [2:0]  rho;
  reg         bad;
  wire        accept;
  wire        fifoClear;
  wire        fifoInReady;
  wire [7:0]  fifoData;
  wire        fifoOutValid;
  wire [31:0] synd;
  wire [39:0] gamma;
  wire [2:0]  eraseCnt;
  reg  [7:0]  delta;
  reg  [7:0]  deltaInv;
  reg  [39:0] next_lam;
  reg  [39:0] next_bpol;
  reg  [3:0]  next_lenL;
  reg  [39:0] startLam;
  reg  [31:0] startOm;
  reg  [39:0] stepLam;
  reg  [31:0] stepOm;
  reg  [7:0]  omk;
  reg  [7:0]  lamSum;
  reg  [7:0]  oddSum;
  reg  [7:0]  omSum;
  reg  [3:0]  degree;
  reg  [7:0]  errVal;
  reg         isRoot;
  integer     i;
  integer     j;

  function [7:0] gfMul;
    input [7:0] a;
    input [7:0] b;
    integer     q;
    reg [7:0]   r;
    begin
      r = 8'h00;
      for (q = 7; q >= 0; q = q - 1) begin
        r = {r[6:0], 1'b0} ^ (r[7] ? `RSD_PRIM_POLY : 8'h00);
        if (b[q]) r = r ^ a;
      end
      gfMul = r;
    end
  endfunction

  function [7:0] gfPowA;
    input integer e;
    integer       q;
    reg [7:0]     r;
    begin
      r = 8'h01;
      for (q = 0; q < 255; q = q + 1) begin
        if (q < e) r = gfMul(r, 8'h02);
      end
      gfPowA = r;
    end
  endfunction

  // x^254 by seven square-and-multiply steps; zero maps to zero
  function [7:0] gfInv;
    input [7:0] x;
    integer     q;
    reg [7:0]   p;
    reg [7:0]   r;
    begin
      r = 8'h01;
      p = x;
      for (q = 0; q < 7; q = q + 1) begin
        p = gfMul(p, p);
        r = gfMul(r, p);
      end
      gfInv = r;
    end
  endfunction

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) rstPipe <= 2'h0;
    else rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstn = rstPipe[1];

  // a codeword only starts on a sync; stray symbols before it are dropped
  assign accept    = clock_gate_enable & symbolReady & fifoInReady & (syncFlag | (cnt != 6'h00));
  assign fifoClear = accept & syncFlag & (cnt != 6'h00);

  rsd_syndrome u_syndrome (
    .clock    (clock),
    .rstn     (rstn),
    .take     (accept),
    .first    (syncFlag),
    .sym      (rx_symbol_in),
    .erase    (eraseFlag),
    .synd     (synd),
    .gamma    (gamma),
    .eraseCnt (eraseCnt)
  );

  // whole codeword waits here until its correction values are known
  rsd_fifo #(
    .WIDTH (`RSD_SYM_W),
    .DEPTH (`RSD_FIFO_DEPTH),
    .AW    (`RSD_FIFO_AW)
  ) u_delay (
    .clock    (clock),
    .rstn     (rstn),
    .clear    (fifoClear),
    .inData   (rx_symbol_in),
    .inValid  (accept),
    .inReady  (fifoInReady),
    .outData  (fifoData),
    .outValid (fifoOutValid),
    .outReady (state == ST_FIX)
  );

  always @* begin
    // berlekamp-massey step seeded with the erasure locator
    delta = 8'h00;
    for (i = 0; i <= `RSD_NPAR; i = i + 1) begin
      if (i <= kr) delta = delta ^ gfMul(lam[i*8 +: 8], synd[(kr-i)*8 +: 8]);
    end
    deltaInv  = gfInv(delta);
    next_lam  = lam;
    next_bpol = {bpol[31:0], 8'h00};
    next_lenL = lenL;
    for (i = 1; i <= `RSD_NPAR; i = i + 1) begin
      next_lam[i*8 +: 8] = lam[i*8 +: 8] ^ gfMul(delta, bpol[(i-1)*8 +: 8]);
    end
    if (delta != 8'h00 && {lenL, 1'b0} <= ({2'h0, kr} + {2'h0, rho})) begin
      for (i = 0; i <= `RSD_NPAR; i = i + 1) begin
        next_bpol[i*8 +: 8] = gfMul(lam[i*8 +: 8], deltaInv);
      end
      next_lenL = {1'b0, kr} + 4'h1 + {1'b0, rho} - lenL;
    end
    // evaluator = syndromes times locator, mod x^2t; chien starts at X = a^(n-1)
    for (i = 0; i <= `RSD_NPAR; i = i + 1) begin
      startLam[i*8 +: 8] = gfMul(lam[i*8 +: 8], gfPowA((i * (255 - (`RSD_N - 1))) % 255));
      stepLam[i*8 +: 8]  = gfMul(lamTerm[i*8 +: 8], gfPowA(i));
    end
    for (i = 0; i < `RSD_NPAR; i = i + 1) begin
      omk = 8'h00;
      for (j = 0; j <= i; j = j + 1) begin
        omk = omk ^ gfMul(lam[j*8 +: 8], synd[(i-j)*8 +: 8]);
      end
      startOm[i*8 +: 8] = gfMul(omk, gfPowA((i * (255 - (`RSD_N - 1))) % 255));
      stepOm[i*8 +: 8]  = gfMul(omTerm[i*8 +: 8], gfPowA(i));
    end
    lamSum = 8'h00;
    omSum  = 8'h00;
    degree = 4'h0;
    for (i = 0; i <= `RSD_NPAR; i = i + 1) begin
      lamSum = lamSum ^ lamTerm[i*8 +: 8];
      if (lam[i*8 +: 8] != 8'h00) degree = i[3:0];
    end
    for (i = 0; i < `RSD_NPAR; i = i + 1) begin
      omSum = omSum ^ omTerm[i*8 +: 8];
    end
    oddSum = lamTerm[15:8] ^ lamTerm[31:24];
    isRoot = (lamSum == 8'h00);
    // forney with first root a^0: value = omega / (odd part of locator)
    errVal = (isRoot && !bad) ? gfMul(omSum, gfInv(oddSum)) : 8'h00;
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state                    <= ST_COLLECT;
      cnt                      <= 6'h00;
      kr                       <= 3'h0;
      lam                      <= 40'h00_0000_0001;
      bpol                     <= 40'h00_0000_0001;
      lenL                     <= 4'h0;
      rho                      <= 3'h0;
      lamTerm                  <= 40'h00_0000_0000;
      omTerm                   <= 32'h0000_0000;
      rootCnt                  <= 4'h0;
      bad                      <= 1'b0;
      symbolReady              <= 1'b0;
      fixed_symbol_out         <= 8'h00;
      message_valid_flag       <= 1'b0;
      correctedFlag            <= 1'b0;
      uncorrectable_block_flag <= 1'b0;
    end else begin
      message_valid_flag       <= 1'b0;
      correctedFlag            <= 1'b0;
      uncorrectable_block_flag <= 1'b0;
      case (state)
        ST_COLLECT: begin
          symbolReady <= 1'b1;
          if (accept) begin
            if (syncFlag) cnt <= 6'h01;
            else cnt <= cnt + 6'h01;
            if ((syncFlag && `RSD_N == 6'h01) || (!syncFlag && cnt == `RSD_LAST)) begin
              state       <= ST_INIT;
              symbolReady <= 1'b0;
            end
          end
        end
        ST_INIT: begin
          lam   <= gamma;
          bpol  <= gamma;
          lenL  <= {1'b0, eraseCnt};
          rho   <= eraseCnt;
          kr    <= 3'h0;
          bad   <= (eraseCnt > `RSD_ERASE_MAX);
          state <= ST_KEY;
        end
        ST_KEY: begin
          // first rho iterations are absorbed by the erasure seed
          if (kr >= rho && !bad) begin
            lam  <= next_lam;
            bpol <= next_bpol;
            lenL <= next_lenL;
          end
          kr <= kr + 3'h1;
          if (kr == `RSD_KEY_LAST) state <= ST_OMEGA;
        end
        ST_OMEGA: begin
          lamTerm <= startLam;
          omTerm  <= startOm;
          rootCnt <= 4'h0;
          cnt     <= 6'h00;
          state   <= ST_CHECK;
        end
        ST_CHECK: begin
          // dry run counts roots so the flag can cover the whole codeword
          cnt <= cnt + 6'h01;
          if (isRoot) rootCnt <= rootCnt + 4'h1;
          lamTerm <= stepLam;
          omTerm  <= stepOm;
          if (cnt == `RSD_LAST) begin
            lamTerm <= startLam;
            omTerm  <= startOm;
            cnt     <= 6'h00;
            state   <= ST_FIX;
            if (degree != lenL || (rootCnt + {3'h0, isRoot}) != lenL) bad <= 1'b1;
          end
        end
        ST_FIX: begin
          if (fifoOutValid) begin
            fixed_symbol_out         <= fifoData ^ errVal;
            message_valid_flag       <= (cnt < `RSD_K);
            correctedFlag            <= (cnt < `RSD_K) && (errVal != 8'h00);
            uncorrectable_block_flag <= bad;
            lamTerm                  <= stepLam;
            omTerm                   <= stepOm;
            cnt                      <= cnt + 6'h01;
            if (cnt == `RSD_LAST) begin
              cnt         <= 6'h00;
              state       <= ST_COLLECT;
              symbolReady <= 1'b1;
            end
          end
        end
        default: begin
          state <= ST_COLLECT;
        end
      endcase
    end
  end
endmodule // rsd_decoder
`default_nettype wire

/* tb/rsd_decoder_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module rsd_decoder_checker (
  input wire logic clock,                   // system clock
  input wire logic rst_n,                   // asynchronous reset
  input wire logic symbolReady,             // decoder collecting
  input wire logic message_valid_flag,      // message symbol out
  input wire logic correctedFlag,           // altered message symbol out
  input wire logic uncorrectable_block_flag // codeword beyond repair
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [5:0] validRun;
  logic [5:0] badRun;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      validRun <= 6'h00;
      badRun <= 6'h00;
    end else begin
      validRun <= message_valid_flag ? validRun + 6'h01 : 6'h00;
      badRun <= uncorrectable_block_flag ? badRun + 6'h01 : 6'h00;
    end
  end
  msg_run_a: assert property (message_valid_flag |-> validRun < 6'h1c)
    else $error("valid run longer than message");
  msg_count_a: assert property ($fell(message_valid_flag) |-> $past(validRun) == 6'h1b)
    else $error("valid run not 28 cycles");
  bad_span_a: assert property ($fell(uncorrectable_block_flag) |-> $past(badRun) == 6'h1f)
    else $error("uncorrectable flag not 32 cycles");
  bad_start_a: assert property ($rose(uncorrectable_block_flag) |-> $rose(message_valid_flag))
    else $error("uncorrectable flag not aligned to codeword");
  fix_in_msg_a: assert property (correctedFlag |-> message_valid_flag && !uncorrectable_block_flag)
    else $error("corrected flag outside message");
  out_latency_a: assert property ($fell(symbolReady) |-> ##39 $rose(message_valid_flag))
    else $error("output latency wrong");
  ready_back_a: assert property ($fell(message_valid_flag) |-> !symbolReady [*3] ##1 symbolReady)
    else $error("ready not back after parity");
  reset_wake_a: assert property ($rose(rst_n) |-> !symbolReady [*3] ##1 symbolReady)
    else $error("ready timing after reset wrong");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |-> !message_valid_flag && !correctedFlag
      && !uncorrectable_block_flag && !symbolReady)
    else $error("outputs high during reset");
  cover property ($fell(message_valid_flag));
  cover property (correctedFlag);
  cover property ($rose(uncorrectable_block_flag));
endmodule // rsd_decoder_checker
`default_nettype wire

/* tb/rsd_upstream_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rsd_upstream_model (
  input  wire logic       clock,             // system clock
  input  wire logic       symbolReady,       // decoder collecting
  output var  logic [7:0] rx_symbol_in,      // symbol to decoder
  output var  logic       syncFlag,          // first symbol marker
  output var  logic       eraseFlag,         // symbol unreliable
  output var  logic       clock_gate_enable  // symbol qualifier
);
  logic [7:0]  cw [32];
  logic [31:0] eraseMask;
  initial begin
    rx_symbol_in = 8'h00;
    syncFlag = 1'b0;
    eraseFlag = 1'b0;
    clock_gate_enable = 1'b0;
    eraseMask = 32'h0;
  end
  // idle data is inverted so a stale sample cannot pass
  task automatic send(input int len, input bit gappy);
    @(negedge clock);
    while (symbolReady !== 1'b1) @(negedge clock);
    @(posedge clock);
    for (int i = 0; i < len; i++) begin
      if (gappy && i % 3 == 1) begin
        clock_gate_enable <= 1'b0;
        syncFlag <= 1'b0;
        rx_symbol_in <= ~rx_symbol_in;
        @(posedge clock);
      end
      rx_symbol_in <= cw[i];
      syncFlag <= (i == 0);
      eraseFlag <= eraseMask[i];
      clock_gate_enable <= 1'b1;
      @(posedge clock);
    end
    clock_gate_enable <= 1'b0;
    syncFlag <= 1'b0;
    eraseFlag <= 1'b0;
    rx_symbol_in <= ~cw[len-1];
  endtask
endmodule // rsd_upstream_model
`default_nettype wire

/* tb/rsd_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rsd_decoder_tb;
  logic       clock;
  logic       rst_n;
  wire  [7:0] rxSym;
  wire        syncF;
  wire        eraseF;
  wire        enF;
  wire        ready;
  wire  [7:0] fixSym;
  wire        valid;
  wire        corr;
  wire        uncorr;
  int         mismatches;
  int         total_checks;
  int         cycles;
  logic [7:0] g [5];
  logic [7:0] orig [32];

  rsd_upstream_model u_up (.clock(clock), .symbolReady(ready), .rx_symbol_in(rxSym), .syncFlag(syncF),
    .eraseFlag(eraseF), .clock_gate_enable(enF));
  rsd_decoder u_dut (.clock(clock), .rst_n(rst_n), .rx_symbol_in(rxSym), .syncFlag(syncF), .eraseFlag(eraseF),
    .clock_gate_enable(enF), .symbolReady(ready), .fixed_symbol_out(fixSym), .message_valid_flag(valid),
    .correctedFlag(corr), .uncorrectable_block_flag(uncorr));

  function automatic logic [7:0] gm(logic [7:0] a, logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) r ^= a;
      a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1d : 8'h00);
    end
    return r;
  endfunction

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // systematic encoder: message first, parity last
  task automatic build(int seed);
    logic [7:0] p [4];
    logic [7:0] fb;
    p = '{default: 8'h00};
    for (int i = 0; i < 28; i++) begin
      orig[i] = 8'(i * 37 + seed);
      fb = orig[i] ^ p[3];
      p[3] = p[2] ^ gm(fb, g[3]);
      p[2] = p[1] ^ gm(fb, g[2]);
      p[1] = p[0] ^ gm(fb, g[1]);
      p[0] = gm(fb, g[0]);
    end
    for (int i = 0; i < 4; i++) orig[28+i] = p[3-i];
    for (int i = 0; i < 32; i++) u_up.cw[i] = orig[i];
    u_up.eraseMask = 32'h0;
  endtask

  task automatic wait_valid;
    int n;
    n = 0;
    @(negedge clock);
    while (valid !== 1'b1 && n < 400) begin
      n++;
      @(negedge clock);
    end
  endtask

  task automatic expect_out(string name, logic [31:0] errMask, bit bad);
    wait_valid();
    for (int k = 0; k < 32; k++) begin
      check("symbol", fixSym, bad ? u_up.cw[k] : orig[k]);
      check("valid", {7'h0, valid}, {7'h0, k < 28});
      check("corrected", {7'h0, corr}, {7'h0, !bad && k < 28 && errMask[k]});
      check("uncorrectable", {7'h0, uncorr}, {7'h0, bad});
      @(negedge clock);
    end
    $display("test %s done", name);
  endtask

  task automatic t_clean;
    build(3);
    u_up.send(32, 1);
    expect_out("clean", 32'h0, 1'b0);
  endtask

  task automatic t_errors;
    build(5);
    u_up.cw[0] ^= 8'h5a;
    u_up.cw[31] ^= 8'h01;
    u_up.send(32, 0);
    expect_out("errors", 32'h80000001, 1'b0);
  endtask

  task automatic t_erase;
    build(7);
    u_up.cw[2] ^= 8'hff;
    u_up.cw[9] ^= 8'h33;
    u_up.cw[17] ^= 8'h80;
    u_up.cw[27] ^= 8'h0c;
    u_up.eraseMask = 32'h08020204;
    u_up.send(32, 1);
    expect_out("erasures", 32'h08020204, 1'b0);
  endtask

  task automatic t_uncorrectable_block_flag;
    build(9);
    for (int i = 1; i < 6; i++) u_up.cw[i] ^= 8'h21;
    u_up.eraseMask = 32'h0000003e;
    u_up.send(32, 0);
    expect_out("uncorrectable_block_flag", 32'h0, 1'b1);
  endtask

  task automatic t_restart;
    build(11);
    u_up.send(10, 0);
    build(13);
    u_up.send(32, 0);
    expect_out("restart", 32'h0, 1'b0);
  endtask

  task automatic t_reset;
    build(15);
    u_up.send(32, 0);
    wait_valid();
    @(posedge clock);
    rst_n <= 1'b0;
    #1;
    check("valid in reset", {7'h0, valid}, 8'h00);
    check("corrected in reset", {7'h0, corr}, 8'h00);
    check("uncorrectable in reset", {7'h0, uncorr}, 8'h00);
    check("ready in reset", {7'h0, ready}, 8'h00);
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    u_up.send(32, 1);
    expect_out("reset", 32'h0, 1'b0);
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    logic [7:0] root;
    // nonblocking, so every async-reset process is already waiting for the edge
    rst_n <= 1'b0;
    mismatches = 0;
    total_checks = 0;
    g = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    root = 8'h01;
    for (int r = 0; r < 4; r++) begin
      for (int j = 4; j > 0; j--) g[j] = g[j-1] ^ gm(g[j], root);
      g[0] = gm(g[0], root);
      root = gm(root, 8'h02);
    end
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_clean();
    t_errors();
    t_erase();
    t_uncorrectable_block_flag();
    t_restart();
    t_reset();
    print_verdict();
  end
endmodule // rsd_decoder_tb

bind rsd_decoder rsd_decoder_checker u_chk (.clock(clock), .rst_n(rst_n), .symbolReady(symbolReady),
  .message_valid_flag(message_valid_flag), .correctedFlag(correctedFlag),
  .uncorrectable_block_flag(uncorrectable_block_flag));
`default_nettype wire
